// ### logic/swd_map.vh
// register map and timing constants of the supervisory watchdog
`ifndef SWD_MAP_VH
`define SWD_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SWD_ADDR_UNLOCK_KEY   8'h02
`define SWD_ADDR_WINDOW_SUP   8'h03
`define SWD_ADDR_TRIGGER      8'h04
`define SWD_ADDR_SETTINGS     8'h07
`define SWD_ADDR_STATUS       8'h08

// ----------------------------------------------------------------
// reset values and key
// ----------------------------------------------------------------
`define SWD_RST_UNLOCK_KEY    8'h00
`define SWD_RST_SETTINGS      8'h09
`define SWD_RST_WINDOW_SUP    3'h7
`define SWD_UNLOCK_VALUE      8'h5A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SWD_DIS_HI            7
`define SWD_DIS_LO            6
`define SWD_DIS_OFF           2'h1
`define SWD_TOUT_HI           5
`define SWD_TOUT_LO           3
`define SWD_MODE_HI           2
`define SWD_MODE_LO           0
`define SWD_MODE_WINDOW       3'h1
`define SWD_TRIG_BIT          0
`define SWD_STAT_FAIL_BIT     0
`define SWD_STAT_RUN_BIT      1
`define SWD_STAT_START_BIT    2
`define SWD_STAT_RSTREQ_BIT   3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWD_CLK_HZ            20000000
`define SWD_MS_PER_S          1000
`define SWD_CYC_PER_MS        (`SWD_CLK_HZ / `SWD_MS_PER_S)
`define SWD_INIT_MS           12'h12C
`define SWD_RSTREQ_MS         12'h002

`endif

// ### logic/swd_ms_tick.v
// millisecond time base of the supervisory watchdog
`timescale 1ns/10ps
`include "swd_map.vh"
module swd_ms_tick #(
    parameter CYC_PER_MS = `SWD_CYC_PER_MS
) (
    input  wire ref_clk_i,
    input  wire rst_n_i,
    input  wire restart_i,
    output reg  tick_o
);

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
reg [24:0] count;

// restart realigns the tick so a service starts a full millisecond
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        count  <= 25'h000_0000;
        tick_o <= 1'b0;
    end
    else if (restart_i)
    begin
        count  <= 25'h000_0000;
        tick_o <= 1'b0;
    end
    else if (count == CYC_PER_MS[24:0] - 25'h000_0001)
    begin
        count  <= 25'h000_0000;
        tick_o <= 1'b1;
    end
    else
    begin
        count  <= count + 25'h000_0001;
        tick_o <= 1'b0;
    end
end

endmodule

// ### logic/swd_top.v
// supervisory watchdog: start-up, window and time-out supervision
// Functional notes
// - after start-up a 300 ms start-up watchdog waits for the first service.
// - in window mode a service counts only in the open half of the window period.
// - settings are writable only while the unlock key register holds the key.
// - disable field 01 stops the watchdog and a 3-bit field picks the time-out period.
// - periods are nominal and the checking side must allow plus or minus 25 percent.
// - all watchdog registers are reached through the host command port.
// - writing 1 to trigger bit 0 at offset 0x04 restarts the counter and self-clears.
// - a 3-bit field picks the window period from 10 ms to 400 ms.
`timescale 1ns/10ps
`include "swd_map.vh"
module swd_top #(
    parameter CYC_PER_MS = `SWD_CYC_PER_MS
) (
    input  wire       ref_clk_i,
    input  wire       reset_n_i,
    input  wire       cmd_wr_i,
    input  wire       cmd_rd_i,
    input  wire [7:0] cmd_addr_i,
    input  wire [7:0] cmd_wdata_i,
    output reg  [7:0] cmd_rdata_o,
    output reg        wd_fail_o,
    output reg        reset_req_o
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam ST_START = 3'b001;
localparam ST_RUN   = 3'b010;
localparam ST_FAIL  = 3'b100;

// ----------------------------------------------------------------
// period lookups in milliseconds
// ----------------------------------------------------------------
function [11:0] tout_ms;
    input [2:0] sel;
    begin
        case (sel)
            3'h0:    tout_ms = 12'h050;
            3'h1:    tout_ms = 12'h0A0;
            3'h2:    tout_ms = 12'h140;
            3'h3:    tout_ms = 12'h1E0;
            3'h4:    tout_ms = 12'h320;
            3'h5:    tout_ms = 12'h3E8;
            default: tout_ms = 12'h3E8; // undefined codes take the longest
        endcase
    end
endfunction

function [11:0] window_ms;
    input [2:0] sel;
    begin
        case (sel)
            3'h0:    window_ms = 12'h00A;
            3'h1:    window_ms = 12'h028;
            3'h2:    window_ms = 12'h050;
            3'h3:    window_ms = 12'h078;
            3'h4:    window_ms = 12'h0A0;
            3'h5:    window_ms = 12'h0F0;
            3'h6:    window_ms = 12'h140;
            default: window_ms = 12'h190;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// reset synchroniser
// ----------------------------------------------------------------
reg rst_meta;
reg rst_n;

// release is synchronous; assertion stays asynchronous
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        rst_meta <= 1'b0;
        rst_n    <= 1'b0;
    end
    else
    begin
        rst_meta <= 1'b1;
        rst_n    <= rst_meta;
    end
end

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
reg  [7:0]  unlock_key;
reg  [7:0]  watchdog_settings;
reg  [2:0]  window_supervisor_register;
wire        unlocked;
wire        hit_key;
wire        hit_settings;
wire        hit_window;
wire        hit_status;
wire        service;
wire        wd_enabled;
wire        window_mode;
reg  [2:0]  state;
reg  [2:0]  next_state;
reg  [11:0] ms_count;
reg  [11:0] next_ms_count;
reg         fail_event;
wire        ms_tick;
wire        fail_clear;

assign hit_key      = cmd_wr_i && (cmd_addr_i == `SWD_ADDR_UNLOCK_KEY);
assign hit_settings = cmd_wr_i && (cmd_addr_i == `SWD_ADDR_SETTINGS);
assign hit_window   = cmd_wr_i && (cmd_addr_i == `SWD_ADDR_WINDOW_SUP);
assign hit_status   = cmd_wr_i && (cmd_addr_i == `SWD_ADDR_STATUS);
assign unlocked     = (unlock_key == `SWD_UNLOCK_VALUE);
// trigger bit is never stored, so it reads back as zero
assign service      = cmd_wr_i && (cmd_addr_i == `SWD_ADDR_TRIGGER)
                      && cmd_wdata_i[`SWD_TRIG_BIT];
assign fail_clear   = hit_status && cmd_wdata_i[`SWD_STAT_FAIL_BIT];
assign wd_enabled   = (watchdog_settings[`SWD_DIS_HI:`SWD_DIS_LO]
                       != `SWD_DIS_OFF);
assign window_mode  = (watchdog_settings[`SWD_MODE_HI:`SWD_MODE_LO]
                       == `SWD_MODE_WINDOW);

// key is free to write; settings and window period need the key
always @(posedge ref_clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        unlock_key                 <= `SWD_RST_UNLOCK_KEY;
        watchdog_settings          <= `SWD_RST_SETTINGS;
        window_supervisor_register <= `SWD_RST_WINDOW_SUP;
    end
    else
    begin
        if (hit_key)
            unlock_key <= cmd_wdata_i;
        if (hit_settings && unlocked)
            watchdog_settings <= cmd_wdata_i;
        if (hit_window && unlocked)
            window_supervisor_register <= cmd_wdata_i[2:0];
    end
end

// read data registered one cycle after the strobe; unmapped reads zero
always @(posedge ref_clk_i or negedge rst_n)
begin
    if (!rst_n)
        cmd_rdata_o <= 8'h00;
    else if (cmd_rd_i)
    begin
        case (cmd_addr_i)
            `SWD_ADDR_UNLOCK_KEY: cmd_rdata_o <= unlock_key;
            `SWD_ADDR_SETTINGS:   cmd_rdata_o <= watchdog_settings;
            `SWD_ADDR_WINDOW_SUP: cmd_rdata_o <= {5'h00, window_supervisor_register};
            `SWD_ADDR_STATUS:     cmd_rdata_o <= {4'h0, reset_req_o, state[0],
                                                  state[1], wd_fail_o};
            default:              cmd_rdata_o <= 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
swd_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n),
    .restart_i (service || (state != next_state)),
    .tick_o    (ms_tick)
);

// ----------------------------------------------------------------
// supervision sequencer
// ----------------------------------------------------------------
// periods are nominal; real silicon drifts up to 25 percent
always @*
begin
    next_state    = state;
    next_ms_count = ms_count;
    fail_event    = 1'b0;
    case (state)
        ST_START:
        begin
            if (!wd_enabled)
                next_ms_count = 12'h000;
            else if (service)
            begin
                next_state    = ST_RUN;
                next_ms_count = 12'h000;
            end
            else if (ms_tick && (ms_count == `SWD_INIT_MS - 12'h001))
            begin
                next_state    = ST_FAIL;
                next_ms_count = 12'h000;
                fail_event    = 1'b1;
            end
            else if (ms_tick)
                next_ms_count = ms_count + 12'h001;
        end
        ST_RUN:
        begin
            if (!wd_enabled)
                next_ms_count = 12'h000;
            else if (service && window_mode &&
                     (ms_count < (window_ms(window_supervisor_register) >> 1)))
            begin
                next_state    = ST_FAIL;
                next_ms_count = 12'h000;
                fail_event    = 1'b1;
            end
            else if (service)
                next_ms_count = 12'h000;
            else if (ms_tick && (ms_count == (window_mode ?
                     window_ms(window_supervisor_register) :
                     tout_ms(watchdog_settings[`SWD_TOUT_HI:`SWD_TOUT_LO])) - 12'h001))
            begin
                next_state    = ST_FAIL;
                next_ms_count = 12'h000;
                fail_event    = 1'b1;
            end
            else if (ms_tick)
                next_ms_count = ms_count + 12'h001;
        end
        ST_FAIL:
        begin
            // hold the reset request, then re-arm the start-up watchdog
            if (ms_tick && (ms_count == `SWD_RSTREQ_MS - 12'h001))
            begin
                next_state    = ST_START;
                next_ms_count = 12'h000;
            end
            else if (ms_tick)
                next_ms_count = ms_count + 12'h001;
        end
        default:
        begin
            next_state    = ST_START;
            next_ms_count = 12'h000;
        end
    endcase
end

// state, counter and failure outputs
always @(posedge ref_clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        state       <= ST_START;
        ms_count    <= 12'h000;
        wd_fail_o   <= 1'b0;
        reset_req_o <= 1'b0;
    end
    else
    begin
        state       <= next_state;
        ms_count    <= next_ms_count;
        reset_req_o <= (next_state == ST_FAIL);
        // a new failure wins over a clear in the same cycle
        if (fail_event)
            wd_fail_o <= 1'b1;
        else if (fail_clear)
            wd_fail_o <= 1'b0;
    end
end

endmodule

// ### dv/swd_top_props.sv
// port assertions of the supervisory watchdog
`include "swd_map.vh"
`timescale 1ns/10ps
module swd_top_props #(
    parameter int CYC_PER_MS = 20000
) (
    input wire       ref_clk_i,
    input wire       reset_n_i,
    input wire       cmd_wr_i,
    input wire       cmd_rd_i,
    input wire [7:0] cmd_addr_i,
    input wire [7:0] cmd_wdata_i,
    input wire [7:0] cmd_rdata_o,
    input wire       wd_fail_o,
    input wire       reset_req_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    localparam int REQ_LO = 3 * CYC_PER_MS / 2;
    localparam int REQ_HI = 5 * CYC_PER_MS / 2;
    reg [15:0] req_cnt;
    wire       clr_wr;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // fail clear write to the status register
    assign clr_wr = cmd_wr_i && cmd_addr_i == `SWD_ADDR_STATUS && cmd_wdata_i[0];
    // length of the reset request, tolerance on the ms base
    always @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            req_cnt <= 16'h0000;
        else if (reset_req_o)
            req_cnt <= req_cnt + 16'h0001;
        else
            req_cnt <= 16'h0000;
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_key_wr;
        cmd_wr_i && cmd_addr_i == `SWD_ADDR_UNLOCK_KEY ##2
        cmd_rd_i && cmd_addr_i == `SWD_ADDR_UNLOCK_KEY;
    endsequence
    sequence s_clear;
        wd_fail_o && !reset_req_o && clr_wr;
    endsequence
    property p_key_rw;
        s_key_wr |=> cmd_rdata_o == $past(cmd_wdata_i, 3);
    endproperty
    property p_unmapped;
        cmd_rd_i && !(cmd_addr_i inside {8'h02, 8'h03, 8'h04, 8'h07, 8'h08})
        |=> cmd_rdata_o == 8'h00;
    endproperty
    property p_trig_zero;
        cmd_rd_i && cmd_addr_i == `SWD_ADDR_TRIGGER |=> cmd_rdata_o == 8'h00;
    endproperty
    property p_win_upper;
        cmd_rd_i && cmd_addr_i == `SWD_ADDR_WINDOW_SUP |=> cmd_rdata_o[7:3] == 5'h00;
    endproperty
    property p_rdata_hold;
        !cmd_rd_i |=> $stable(cmd_rdata_o);
    endproperty
    property p_req_flag;
        $rose(reset_req_o) |-> wd_fail_o;
    endproperty
    property p_req_len;
        $fell(reset_req_o) |-> req_cnt >= REQ_LO && req_cnt <= REQ_HI;
    endproperty
    property p_sticky;
        wd_fail_o && !clr_wr |=> wd_fail_o;
    endproperty
    property p_clear;
        s_clear |=> !wd_fail_o;
    endproperty
    a_key_rw: assert property (p_key_rw) else $error("key readback wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_trig_zero: assert property (p_trig_zero) else $error("trigger read");
    a_win_upper: assert property (p_win_upper) else $error("window bits");
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    a_req_flag: assert property (p_req_flag) else $error("request no fail");
    a_req_len: assert property (p_req_len) else $error("request length");
    a_sticky: assert property (p_sticky) else $error("fail dropped");
    a_clear: assert property (p_clear) else $error("fail not cleared");
endmodule

bind swd_top swd_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .cmd_wr_i    (cmd_wr_i),
    .cmd_rd_i    (cmd_rd_i),
    .cmd_addr_i  (cmd_addr_i),
    .cmd_wdata_i (cmd_wdata_i),
    .cmd_rdata_o (cmd_rdata_o),
    .wd_fail_o   (wd_fail_o),
    .reset_req_o (reset_req_o)
);

// ### dv/swd_host_model.sv
// host model driving the watchdog command port
`timescale 1ns/10ps
module swd_host_model (
    input  wire       ref_clk_i,
    output reg        cmd_wr_o,
    output reg        cmd_rd_o,
    output reg  [7:0] cmd_addr_o,
    output reg  [7:0] cmd_wdata_o
);
    // idle port from time zero
    initial
    begin
        cmd_wr_o    = 1'b0;
        cmd_rd_o    = 1'b0;
        cmd_addr_o  = 8'hFF;
        cmd_wdata_o = 8'hFF;
    end
    // one-cycle strobe, then an idle edge so strobes never collide
    task wr(input [7:0] a, input [7:0] d);
    begin
        cmd_wr_o    <= 1'b1;
        cmd_addr_o  <= a;
        cmd_wdata_o <= d;
        @(posedge ref_clk_i);
        cmd_wr_o    <= 1'b0;
        cmd_wdata_o <= ~d; // stale data not left on the lines
        @(posedge ref_clk_i);
    end
    endtask
    task rd(input [7:0] a);
    begin
        cmd_rd_o   <= 1'b1;
        cmd_addr_o <= a;
        @(posedge ref_clk_i);
        cmd_rd_o   <= 1'b0;
        @(posedge ref_clk_i);
    end
    endtask
    // key first, then settings
    task unlock_cfg(input [7:0] s);
    begin
        wr(`SWD_ADDR_UNLOCK_KEY, `SWD_UNLOCK_VALUE);
        wr(`SWD_ADDR_SETTINGS, s);
    end
    endtask
    // service: trigger bit 0, timed by caller inside the window
    task svc;
    begin
        wr(`SWD_ADDR_TRIGGER, 8'h01);
    end
    endtask
endmodule

// ### dv/supervisory_watchdog_tb.sv
// self-checking bench of the supervisory watchdog
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, s); end end
module supervisory_watchdog_tb;
    localparam int CYC = 10;
    reg        ref_clk_i = 1'b0;
    reg        reset_n_i = 1'b0;
    wire       wr, rd, fail, req;
    wire [7:0] addr, wdata, rdata;
    int        n_fail = 0;
    int        checks = 0;
    int        tsel;
    reg  [7:0] k;
    reg        rd_d = 1'b0;
    reg  [7:0] q[$];
    int        per[6] = '{80, 160, 320, 480, 800, 1000};
    swd_host_model host (.ref_clk_i(ref_clk_i), .cmd_wr_o(wr), .cmd_rd_o(rd),
        .cmd_addr_o(addr), .cmd_wdata_o(wdata));
    swd_top #(.CYC_PER_MS(CYC)) uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_addr_i(addr), .cmd_wdata_i(wdata),
        .cmd_rdata_o(rdata), .wd_fail_o(fail), .reset_req_o(req));
    // 20 MHz clock
    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task complete_run;
    begin
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // read data lands one cycle after the read edge
    always @(posedge ref_clk_i)
    begin
        if (rd_d)
        begin
            if (q.size() == 0)
            begin
                n_fail++;
                $display("MISMATCH rdata_queue exp=1 got=0");
            end
            else
                `CHK("rdata", q.pop_front(), rdata)
        end
        rd_d <= rd;
    end
    task rd_chk(input [7:0] a, input [7:0] e);
    begin
        q.push_back(e);
        host.rd(a);
    end
    endtask
    // failure inside [lo,hi) cycles, then request ends and flag is cleared
    task wait_fail(input int lo, input int hi);
        int n;
    begin
        n = 0;
        while (fail !== 1'b1 && n < hi)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        `CHK("fail_time", 1'b1, (n >= lo && n < hi))
        `CHK("req_on", 1'b1, req)
        n = 0;
        while (req !== 1'b0 && n < 40 * CYC)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        `CHK("req_end", 1'b0, req)
        host.wr(`SWD_ADDR_STATUS, 8'h01);
        `CHK("fail_clr", 1'b0, fail)
    end
    endtask
    // hang guard
    initial
    begin
        repeat (60000) @(posedge ref_clk_i);
        n_fail++;
        $display("MISMATCH watchdog exp=done got=hang");
        complete_run;
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(67673));
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd_chk(`SWD_ADDR_UNLOCK_KEY, `SWD_RST_UNLOCK_KEY);
        rd_chk(`SWD_ADDR_SETTINGS, `SWD_RST_SETTINGS);
        rd_chk(`SWD_ADDR_WINDOW_SUP, {5'h00, `SWD_RST_WINDOW_SUP});
        rd_chk(`SWD_ADDR_TRIGGER, 8'h00);
        rd_chk(8'h10, 8'h00);
        k = $urandom;
        if (k == `SWD_UNLOCK_VALUE)
            k = 8'h5B;
        host.wr(`SWD_ADDR_UNLOCK_KEY, k);
        rd_chk(`SWD_ADDR_UNLOCK_KEY, k);
        host.wr(`SWD_ADDR_SETTINGS, 8'h40);
        rd_chk(`SWD_ADDR_SETTINGS, `SWD_RST_SETTINGS);
        // start-up supervision with no service, 300 ms nominal
        wait_fail(225 * CYC, 375 * CYC);
        // time-out mode, random period select
        tsel = $urandom % 6;
        host.unlock_cfg({2'b00, tsel[2:0], 3'b000});
        rd_chk(`SWD_ADDR_SETTINGS, {2'b00, tsel[2:0], 3'b000});
        host.svc;
        wait_fail(per[tsel] * CYC * 3 / 4, per[tsel] * CYC * 5 / 4);
        // window mode, 10 ms period: late services pass, an early one fails
        host.wr(`SWD_ADDR_WINDOW_SUP, 8'h00);
        host.wr(`SWD_ADDR_SETTINGS, 8'h01);
        host.svc;
        repeat (3)
        begin
            repeat (75) @(posedge ref_clk_i);
            host.svc;
        end
        `CHK("win_ok", 1'b0, fail)
        repeat (20) @(posedge ref_clk_i);
        host.svc;
        wait_fail(0, 10);
        // disabled watchdog never fails
        host.wr(`SWD_ADDR_SETTINGS, 8'h40);
        repeat (4000) @(posedge ref_clk_i);
        `CHK("disabled", 1'b0, fail)
        complete_run;
    end
endmodule
